/* File: src/status_fault_frame_packer.sv */
`timescale 1ns/100ps
// Operation
// - send the slow status frame once, 10 ms after receive PDO 2 arrives.
// - frame identifier is 0x3E0 plus the configured node identifier.
// - data length code of the slow status frame is always eight.
// - bytes 1-2, 3-4, 5-6 carry status words 4, 5, 6.
// - bytes 7-8 are spare, filled with a fixed meaningless value.
// - status word 3 goes into bytes 7-8 of the sixth transmit PDO.
// - word 3 bits 0-3: heatsink sensor fail, warn high, warn low, critical.
// - word 3 bits 4-5: internal bus voltage sense failed low, high.
// - word 3 bits 6-9: input voltage 1 low/high, input voltage 2 low/high.
// - word 3 bits 10-15: input, phase A, phase B current sensor low/high.
// - word 4 bits 0-3: no board, board changed, miscalibrated, current monitor.
// - word 4 bits 4-8: start-up close/open checks and motor direction faults.
// - word 4 bits 9-15: communication processor status and fault flags.
module status_fault_frame_packer #(
  parameter int unsigned TX_DELAY_CYCLES = frame_packer_pkg::TPDO7_DELAY_CYC
) (
  input  wire logic                                   clk_i,
  input  wire logic                                   rst_n_i,
  input  wire logic [frame_packer_pkg::NODE_ID_W-1:0] node_id_i,
  input  wire logic                                   rpdo2_rx_i,
  input  wire logic                                   hs_sensor_fail_i,
  input  wire logic                                   hs_warn_high_i,
  input  wire logic                                   hs_warn_low_i,
  input  wire logic                                   hs_critical_i,
  input  wire logic                                   bus_sense_low_i,
  input  wire logic                                   bus_sense_high_i,
  input  wire logic                                   vin1_low_i,
  input  wire logic                                   vin1_high_i,
  input  wire logic                                   vin2_low_i,
  input  wire logic                                   vin2_high_i,
  input  wire logic                                   iin_sensor_low_i,
  input  wire logic                                   iin_sensor_high_i,
  input  wire logic                                   pha_sensor_low_i,
  input  wire logic                                   pha_sensor_high_i,
  input  wire logic                                   phb_sensor_low_i,
  input  wire logic                                   phb_sensor_high_i,
  input  wire logic                                   no_power_board_i,
  input  wire logic                                   power_board_changed_i,
  input  wire logic                                   power_board_miscal_i,
  input  wire logic                                   current_monitor_fault_i,
  input  wire logic                                   close_check_motor_i,
  input  wire logic                                   close_check_shaft_i,
  input  wire logic                                   open_check_motor_i,
  input  wire logic                                   open_check_shaft_i,
  input  wire logic                                   motor_direction_fault_i,
  input  wire logic                                   comm_cpu_booting_i,
  input  wire logic                                   comm_cpu_summary_i,
  input  wire logic                                   comm_cpu_missing_i,
  input  wire logic                                   comm_cpu_wrong_type_i,
  input  wire logic                                   comm_cpu_dpram_fail_i,
  input  wire logic                                   comm_cpu_timeout_i,
  input  wire logic                                   comm_cpu_heartbeat_i,
  input  wire logic [frame_packer_pkg::WORD_W-1:0]    status5_word_i,
  input  wire logic [frame_packer_pkg::WORD_W-1:0]    status6_word_i,
  input  wire logic                                   tx_ready_i,
  output logic                                        tx_valid_o,
  output logic [frame_packer_pkg::COB_ID_W-1:0]       tx_cob_id_o,
  output logic [frame_packer_pkg::DLC_W-1:0]          tx_dlc_o,
  output logic [frame_packer_pkg::FRAME_W-1:0]        tx_data_o,
  output logic [frame_packer_pkg::WORD_W-1:0]         tpdo6_bytes78_o,
  output logic [frame_packer_pkg::WORD_W-1:0]         driver_power_fault_flags_o,
  output logic [frame_packer_pkg::WORD_W-1:0]         startup_comm_fault_flags_o,
  output logic                                        tx_busy_o
);
  import frame_packer_pkg::*;

  localparam logic [DELAY_CNT_W-1:0] DELAY_LAST = DELAY_CNT_W'(TX_DELAY_CYCLES - 1);

  logic [WORD_W-1:0]      word3;
  logic [WORD_W-1:0]      word4;
  tx_state_t              state_reg;
  tx_state_t              state_next;
  logic [DELAY_CNT_W-1:0] delay_cnt_reg;
  logic                   delay_done;
  logic                   capture;
  logic [FRAME_W-1:0]     data_reg;
  logic [COB_ID_W-1:0]    cob_id_reg;
  logic [WORD_W-1:0]      word3_reg;
  logic [WORD_W-1:0]      word4_reg;
  logic [WORD_W-1:0]      pdo6_reg;

  word_slot_if slot3 ();
  word_slot_if slot4 ();
  word_slot_if slot5 ();
  word_slot_if slot6 ();

  always_comb
  begin
    word3                   = WORD_RESET;
    word3[W3_HS_SENSOR]     = hs_sensor_fail_i;
    word3[W3_HS_WARN_HIGH]  = hs_warn_high_i;
    word3[W3_HS_WARN_LOW]   = hs_warn_low_i;
    word3[W3_HS_CRITICAL]   = hs_critical_i;
    word3[W3_BUS_LOW]       = bus_sense_low_i;
    word3[W3_BUS_HIGH]      = bus_sense_high_i;
    word3[W3_VIN1_LOW]      = vin1_low_i;
    word3[W3_VIN1_HIGH]     = vin1_high_i;
    word3[W3_VIN2_LOW]      = vin2_low_i;
    word3[W3_VIN2_HIGH]     = vin2_high_i;
    word3[W3_IIN_LOW]       = iin_sensor_low_i;
    word3[W3_IIN_HIGH]      = iin_sensor_high_i;
    word3[W3_PHA_LOW]       = pha_sensor_low_i;
    word3[W3_PHA_HIGH]      = pha_sensor_high_i;
    word3[W3_PHB_LOW]       = phb_sensor_low_i;
    word3[W3_PHB_HIGH]      = phb_sensor_high_i;
  end

  always_comb
  begin
    word4                   = WORD_RESET;
    word4[W4_NO_PWR_BOARD]  = no_power_board_i;
    word4[W4_PWR_BOARD_ID]  = power_board_changed_i;
    word4[W4_PWR_BOARD_CAL] = power_board_miscal_i;
    word4[W4_CURRENT_MON]   = current_monitor_fault_i;
    word4[W4_CLOSE_MOTOR]   = close_check_motor_i;
    word4[W4_CLOSE_SHAFT]   = close_check_shaft_i;
    word4[W4_OPEN_MOTOR]    = open_check_motor_i;
    word4[W4_OPEN_SHAFT]    = open_check_shaft_i;
    word4[W4_MOTOR_DIR]     = motor_direction_fault_i;
    word4[W4_CPU_BOOTING]   = comm_cpu_booting_i;
    word4[W4_CPU_SUMMARY]   = comm_cpu_summary_i;
    word4[W4_CPU_MISSING]   = comm_cpu_missing_i;
    word4[W4_CPU_TYPE]      = comm_cpu_wrong_type_i;
    word4[W4_CPU_DPRAM]     = comm_cpu_dpram_fail_i;
    word4[W4_CPU_TIMEOUT]   = comm_cpu_timeout_i;
    word4[W4_CPU_HEARTBEAT] = comm_cpu_heartbeat_i;
  end

  assign slot3.word = word3;
  assign slot4.word = word4;
  assign slot5.word = status5_word_i;
  assign slot6.word = status6_word_i;

  word_slot_packer u_slot3 (
    .slot (slot3.packer)
  );
  word_slot_packer u_slot4 (
    .slot (slot4.packer)
  );
  word_slot_packer u_slot5 (
    .slot (slot5.packer)
  );
  word_slot_packer u_slot6 (
    .slot (slot6.packer)
  );

  assign delay_done = (delay_cnt_reg == DELAY_LAST);
  assign capture    = (state_reg == ST_WAIT) && delay_done;

  // one frame per receive, further receives ignored until sent
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (rpdo2_rx_i)
          state_next = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (delay_done)
          state_next = ST_SEND;
      end
      ST_SEND:
      begin
        if (tx_ready_i)
          state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // delay counter for the 10 ms wait
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      delay_cnt_reg <= '0;
    else if (state_reg != ST_WAIT)
      delay_cnt_reg <= '0;
    else if (!delay_done)
      delay_cnt_reg <= delay_cnt_reg + 1'b1;
  end

  // single cycle snapshot of slots 4, 5 and 6, the spare fill and the identifier
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      data_reg   <= '0;
      cob_id_reg <= TPDO7_COB_BASE;
    end
    else if (capture)
    begin
      // slots for words 4, 5 and 6
      data_reg[SLOT12_LSB +: WORD_W] <= {slot4.second_byte, slot4.first_byte};
      data_reg[SLOT34_LSB +: WORD_W] <= {slot5.second_byte, slot5.first_byte};
      data_reg[SLOT56_LSB +: WORD_W] <= {slot6.second_byte, slot6.first_byte};
      data_reg[SLOT78_LSB +: WORD_W] <= SPARE_FILL;
      cob_id_reg <= TPDO7_COB_BASE + COB_ID_W'(node_id_i);
    end
  end

  // sixth PDO tail and the readable flag registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pdo6_reg  <= WORD_RESET;
      word3_reg <= WORD_RESET;
      word4_reg <= WORD_RESET;
    end
    else
    begin
      pdo6_reg  <= {slot3.second_byte, slot3.first_byte};
      word3_reg <= word3;
      word4_reg <= word4;
    end
  end

  assign tx_valid_o                 = (state_reg == ST_SEND);
  assign tx_busy_o                  = (state_reg != ST_IDLE);
  assign tx_cob_id_o                = cob_id_reg;
  assign tx_dlc_o                   = TPDO7_DLC;
  assign tx_data_o                  = data_reg;
  assign tpdo6_bytes78_o            = pdo6_reg;
  assign driver_power_fault_flags_o = word3_reg;
  assign startup_comm_fault_flags_o = word4_reg;

endmodule // status_fault_frame_packer

/* File: src/frame_packer_pkg.sv */
package frame_packer_pkg;

  // clock and delay timing
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned TPDO7_DELAY_MS   = 10;
  localparam int unsigned TPDO7_DELAY_CYC  = (CLK_HZ / 1000) * TPDO7_DELAY_MS;
  localparam int unsigned DELAY_CNT_W      = 24;

  // frame layout
  localparam int unsigned NODE_ID_W        = 7;
  localparam int unsigned COB_ID_W         = 11;
  localparam int unsigned DLC_W            = 4;
  localparam int unsigned WORD_W           = 16;
  localparam int unsigned BYTE_W           = 8;
  localparam int unsigned FRAME_W          = 64;
  localparam logic [COB_ID_W-1:0] TPDO7_COB_BASE = 11'h3E0;
  localparam logic [DLC_W-1:0]    TPDO7_DLC      = 4'h8;
  localparam logic [WORD_W-1:0]   SPARE_FILL     = 16'h0000;

  // lsb of each two-byte slot inside the data field, byte 1 at bit 0
  localparam int unsigned SLOT12_LSB       = 0;
  localparam int unsigned SLOT34_LSB       = 16;
  localparam int unsigned SLOT56_LSB       = 32;
  localparam int unsigned SLOT78_LSB       = 48;

  // driver and power fault word bit positions
  localparam int unsigned W3_HS_SENSOR     = 0;
  localparam int unsigned W3_HS_WARN_HIGH  = 1;
  localparam int unsigned W3_HS_WARN_LOW   = 2;
  localparam int unsigned W3_HS_CRITICAL   = 3;
  localparam int unsigned W3_BUS_LOW       = 4;
  localparam int unsigned W3_BUS_HIGH      = 5;
  localparam int unsigned W3_VIN1_LOW      = 6;
  localparam int unsigned W3_VIN1_HIGH     = 7;
  localparam int unsigned W3_VIN2_LOW      = 8;
  localparam int unsigned W3_VIN2_HIGH     = 9;
  localparam int unsigned W3_IIN_LOW       = 10;
  localparam int unsigned W3_IIN_HIGH      = 11;
  localparam int unsigned W3_PHA_LOW       = 12;
  localparam int unsigned W3_PHA_HIGH      = 13;
  localparam int unsigned W3_PHB_LOW       = 14;
  localparam int unsigned W3_PHB_HIGH      = 15;

  // start-up and communication fault word bit positions
  localparam int unsigned W4_NO_PWR_BOARD  = 0;
  localparam int unsigned W4_PWR_BOARD_ID  = 1;
  localparam int unsigned W4_PWR_BOARD_CAL = 2;
  localparam int unsigned W4_CURRENT_MON   = 3;
  localparam int unsigned W4_CLOSE_MOTOR   = 4;
  localparam int unsigned W4_CLOSE_SHAFT   = 5;
  localparam int unsigned W4_OPEN_MOTOR    = 6;
  localparam int unsigned W4_OPEN_SHAFT    = 7;
  localparam int unsigned W4_MOTOR_DIR     = 8;
  localparam int unsigned W4_CPU_BOOTING   = 9;
  localparam int unsigned W4_CPU_SUMMARY   = 10;
  localparam int unsigned W4_CPU_MISSING   = 11;
  localparam int unsigned W4_CPU_TYPE      = 12;
  localparam int unsigned W4_CPU_DPRAM     = 13;
  localparam int unsigned W4_CPU_TIMEOUT   = 14;
  localparam int unsigned W4_CPU_HEARTBEAT = 15;

  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SEND = 2'b11
  } tx_state_t;

endpackage

/* File: src/word_slot_if.sv */
`timescale 1ns/100ps
interface word_slot_if;
  import frame_packer_pkg::*;
  logic [WORD_W-1:0] word;
  logic [BYTE_W-1:0] first_byte;
  logic [BYTE_W-1:0] second_byte;

  modport source (output word, input first_byte, input second_byte);
  modport packer (input word, output first_byte, output second_byte);
endinterface

/* File: src/word_slot_packer.sv */
`timescale 1ns/100ps
module word_slot_packer (
  word_slot_if.packer slot
);
  import frame_packer_pkg::*;

  // low byte goes out first on the bus
  assign slot.first_byte  = slot.word[BYTE_W-1:0];
  assign slot.second_byte = slot.word[WORD_W-1:BYTE_W];
endmodule // word_slot_packer

/* File: tb/frame_packer_sva.sv */
`timescale 1ns/100ps
module frame_packer_sva
  import frame_packer_pkg::*;
#(
  parameter int unsigned TX_DELAY_CYCLES = 20
) (
  input wire logic                 clk_i,
  input wire logic                 rst_n_i,
  input wire logic [NODE_ID_W-1:0] node_id_i,
  input wire logic                 rpdo2_rx_i,
  input wire logic                 hs_sensor_fail_i,
  input wire logic                 phb_sensor_high_i,
  input wire logic                 no_power_board_i,
  input wire logic                 comm_cpu_heartbeat_i,
  input wire logic [WORD_W-1:0]    status5_word_i,
  input wire logic [WORD_W-1:0]    status6_word_i,
  input wire logic                 tx_ready_i,
  input wire logic                 tx_valid_o,
  input wire logic [COB_ID_W-1:0]  tx_cob_id_o,
  input wire logic [DLC_W-1:0]     tx_dlc_o,
  input wire logic [FRAME_W-1:0]   tx_data_o,
  input wire logic [WORD_W-1:0]    tpdo6_bytes78_o,
  input wire logic [WORD_W-1:0]    driver_power_fault_flags_o,
  input wire logic                 tx_busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // edges counted from the taking edge, which counts as one; cleared while offered
  logic [DELAY_CNT_W-1:0] wait_cnt_reg;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || tx_valid_o)
      wait_cnt_reg <= '0;
    else if (rpdo2_rx_i && !tx_busy_o)
      wait_cnt_reg <= 24'h000001;
    else if (wait_cnt_reg != '0)
      wait_cnt_reg <= wait_cnt_reg + 24'h000001;
  end
  sequence s_offer_held;
    tx_valid_o && $stable(tx_data_o) && $stable(tx_cob_id_o);
  endsequence
  a_no_early_frame: assert property ($rose(tx_valid_o) |-> wait_cnt_reg == DELAY_CNT_W'(TX_DELAY_CYCLES + 1)) else $error("frame offered off delay");
  a_frame_on_time: assert property (wait_cnt_reg == DELAY_CNT_W'(TX_DELAY_CYCLES + 1) |-> tx_valid_o) else $error("frame late");
  a_cob_id_sum: assert property ($rose(tx_valid_o) |-> tx_cob_id_o == TPDO7_COB_BASE + $past(node_id_i)) else $error("bad identifier");
  a_dlc_eight: assert property (tx_valid_o |-> tx_dlc_o == TPDO7_DLC) else $error("bad length code");
  a_data_words: assert property ($rose(tx_valid_o) |-> tx_data_o[47:16] == {$past(status6_word_i), $past(status5_word_i)}) else $error("bad word 5 or 6");
  a_spare_fill: assert property (tx_valid_o |-> tx_data_o[63:48] == SPARE_FILL) else $error("bad spare bytes");
  a_word4_order: assert property ($rose(tx_valid_o) |-> tx_data_o[0] == $past(no_power_board_i) && tx_data_o[15] == $past(comm_cpu_heartbeat_i)) else $error("bad word 4 order");
  a_word3_bits: assert property ($past(rst_n_i) |-> driver_power_fault_flags_o[0] == $past(hs_sensor_fail_i) && driver_power_fault_flags_o[15] == $past(phb_sensor_high_i)) else $error("bad word 3");
  a_tpdo6_copy: assert property (tpdo6_bytes78_o == driver_power_fault_flags_o) else $error("pdo6 slot differs");
  a_offer_held: assert property (tx_valid_o && !tx_ready_i |=> s_offer_held) else $error("offer changed");
  a_offer_ends: assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o && !tx_busy_o) else $error("offer not ended");
endmodule // frame_packer_sva
bind status_fault_frame_packer frame_packer_sva #(.TX_DELAY_CYCLES(TX_DELAY_CYCLES)) i_frame_packer_sva (
  .clk_i, .rst_n_i, .node_id_i, .rpdo2_rx_i, .hs_sensor_fail_i, .phb_sensor_high_i,
  .no_power_board_i, .comm_cpu_heartbeat_i, .status5_word_i, .status6_word_i, .tx_ready_i,
  .tx_valid_o, .tx_cob_id_o, .tx_dlc_o, .tx_data_o, .tpdo6_bytes78_o,
  .driver_power_fault_flags_o, .tx_busy_o);

/* File: tb/can_ctrl_model.sv */
`timescale 1ns/100ps
module can_ctrl_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  stall_i,
  input  wire logic        valid_i,
  input  wire logic [10:0] id_i,
  input  wire logic [63:0] data_i,
  output logic             ready_o,
  output logic [10:0]      got_id_o,
  output logic [63:0]      got_data_o,
  output logic [7:0]       got_cnt_o
);
  logic [7:0] wait_reg;
  // raises ready after stall_i + 1 cycles of offer, accepts one frame on the next edge
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ready_o <= 1'b0;
      wait_reg <= 8'h00;
      got_cnt_o <= 8'h00;
    end
    else if (valid_i && ready_o)
    begin
      ready_o <= 1'b0;
      wait_reg <= 8'h00;
      got_id_o <= id_i;
      got_data_o <= data_i;
      got_cnt_o <= got_cnt_o + 8'h01;
    end
    else if (valid_i)
    begin
      ready_o <= (wait_reg == stall_i);
      wait_reg <= wait_reg + 8'h01;
    end
  end
endmodule // can_ctrl_model

/* File: tb/test_status_fault_frame_packer.sv */
`timescale 1ns/100ps
module test_status_fault_frame_packer;
  import frame_packer_pkg::*;
  localparam int unsigned DLY = 20;
  typedef struct packed {
    logic [15:0] w3, w4, s5, s6;
    logic [6:0]  nid;
    logic [7:0]  stall;
  } row_t;
  row_t rows [4] = '{
    '{16'h0001, 16'h8000, 16'h1234, 16'hABCD, 7'h00, 8'h00},
    '{16'h8000, 16'h0001, 16'hFFFF, 16'h0000, 7'h7F, 8'h03},
    '{16'hA5C3, 16'h5A3C, 16'h00FF, 16'hFF00, 7'h01, 8'h00},
    '{16'hFFFF, 16'hFFFF, 16'h8001, 16'h7FFE, 7'h2A, 8'h05}};
  logic        clk_i, rst_n_i, rpdo2_rx_i, tx_ready_i, tx_valid_o, tx_busy_o;
  logic [6:0]  node_id_i;
  logic [15:0] w3, w4, s5, s6, tpdo6_bytes78_o, dpf_o, scf_o;
  logic [10:0] tx_cob_id_o, got_id;
  logic [3:0]  tx_dlc_o;
  logic [63:0] tx_data_o, got_data;
  logic [7:0]  stall, got_cnt;
  int          bad_count = 0, compares = 0, lat;
  status_fault_frame_packer #(.TX_DELAY_CYCLES(DLY)) i_status_fault_frame_packer (
    .clk_i, .rst_n_i, .node_id_i, .rpdo2_rx_i, .tx_ready_i, .tx_valid_o, .tx_cob_id_o,
    .tx_dlc_o, .tx_data_o, .tpdo6_bytes78_o, .tx_busy_o, .status5_word_i(s5),
    .status6_word_i(s6), .driver_power_fault_flags_o(dpf_o), .startup_comm_fault_flags_o(scf_o),
    .hs_sensor_fail_i(w3[0]), .hs_warn_high_i(w3[1]), .hs_warn_low_i(w3[2]),
    .hs_critical_i(w3[3]), .bus_sense_low_i(w3[4]), .bus_sense_high_i(w3[5]),
    .vin1_low_i(w3[6]), .vin1_high_i(w3[7]), .vin2_low_i(w3[8]), .vin2_high_i(w3[9]),
    .iin_sensor_low_i(w3[10]), .iin_sensor_high_i(w3[11]), .pha_sensor_low_i(w3[12]),
    .pha_sensor_high_i(w3[13]), .phb_sensor_low_i(w3[14]), .phb_sensor_high_i(w3[15]),
    .no_power_board_i(w4[0]), .power_board_changed_i(w4[1]), .power_board_miscal_i(w4[2]),
    .current_monitor_fault_i(w4[3]), .close_check_motor_i(w4[4]),
    .close_check_shaft_i(w4[5]), .open_check_motor_i(w4[6]), .open_check_shaft_i(w4[7]),
    .motor_direction_fault_i(w4[8]), .comm_cpu_booting_i(w4[9]),
    .comm_cpu_summary_i(w4[10]), .comm_cpu_missing_i(w4[11]),
    .comm_cpu_wrong_type_i(w4[12]), .comm_cpu_dpram_fail_i(w4[13]),
    .comm_cpu_timeout_i(w4[14]), .comm_cpu_heartbeat_i(w4[15]));
  can_ctrl_model i_can_ctrl_model (.clk_i, .rst_n_i, .stall_i(stall), .valid_i(tx_valid_o),
    .id_i(tx_cob_id_o), .data_i(tx_data_o), .ready_o(tx_ready_i), .got_id_o(got_id),
    .got_data_o(got_data), .got_cnt_o(got_cnt));
  task automatic results();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk_i);
    #2;
  endtask
  task automatic apply(input row_t r);
    {w3, w4, s5, s6, node_id_i, stall} = r;
  endtask
  // one trigger pulse, an optional second one at cycle retrig, wait for acceptance
  // lat counts the taking edge too, so valid is seen DLY + 1 ticks after the pulse
  task automatic frame(input int retrig, input bit flip);
    logic [7:0] n;
    int g;
    n = got_cnt;
    rpdo2_rx_i = 1'b1;
    lat = 0;
    while (!tx_valid_o && lat < 100)
    begin
      tick();
      lat++;
      rpdo2_rx_i = (lat == retrig);
    end
    if (flip)
      {w4, s6} = ~{w4, s6};
    for (g = 0; g < 300 && got_cnt == n; g++)
      tick();
  endtask
  task automatic check_row(input row_t r);
    chk(64'(lat), 64'(DLY + 1));
    chk(64'(got_id), 64'(11'h3E0 + {4'h0, r.nid}));
    chk(64'(tx_dlc_o), 64'h8);
    chk(got_data, {16'h0000, r.s6, r.s5, r.w4});
    chk(64'({tpdo6_bytes78_o, dpf_o, scf_o}), 64'({r.w3, r.w3, r.w4}));
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial
  begin
    #(25 * 5000);
    bad_count++;
    results();
  end
  initial
  begin
    rst_n_i = 1'b0;
    rpdo2_rx_i = 1'b0;
    apply(rows[0]);
    repeat (6) tick();
    rst_n_i = 1'b1;
    foreach (rows[i])
    begin
      apply(rows[i]);
      frame(0, 1'b0);
      check_row(rows[i]);
    end
    // retrigger while busy is ignored, inputs changed during the offer are not taken
    apply(rows[3]);
    frame(5, 1'b1);
    chk(64'(lat), 64'(DLY + 1));
    chk(got_data, {16'h0000, rows[3].s6, rows[3].s5, rows[3].w4});
    repeat (3 * DLY) tick();
    chk(64'(got_cnt), 64'h5);
    // reset while the far side stalls the offer, then recover
    apply(rows[1]);
    stall = 8'hFF;
    rpdo2_rx_i = 1'b1;
    tick();
    rpdo2_rx_i = 1'b0;
    repeat (DLY + 4) tick();
    chk(64'({tx_valid_o, tx_busy_o, got_cnt}), 64'({2'b11, 8'h05}));
    rst_n_i = 1'b0;
    repeat (2) tick();
    chk(64'({tx_valid_o, tx_busy_o, tx_dlc_o, tx_cob_id_o}), 64'({2'b00, 4'h8, 11'h3E0}));
    chk(tx_data_o | 64'({tpdo6_bytes78_o, dpf_o, scf_o}), 64'h0);
    rst_n_i = 1'b1;
    apply(rows[1]);
    frame(0, 1'b0);
    check_row(rows[1]);
    results();
  end
endmodule // test_status_fault_frame_packer
